// file: hdl/lccf_conv_timer.sv
// Conversion period timer with restart and abort.
`timescale 1ns/1ps
`default_nettype none
module lccf_conv_timer
   import lccf_pkg::*;
#(
   parameter int unsigned SHORT_CYC = 12500000,
   parameter int unsigned LONG_CYC  = 100000000,
   parameter int          CNT_W     = 27
) (
   // Clock and control.
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic ce,
   // Timer requests.
   input  wire logic start,
   input  wire logic abort,
   input  wire logic long_sel,
   // Period end.
   output logic      done
);
   logic             busy_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] last_reg;

   assign done = busy_reg && (cnt_reg == last_reg);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         busy_reg <= 1'b0;
         cnt_reg  <= '0;
         last_reg <= '0;
      end else if (ce) begin
         if (start) begin
            busy_reg <= 1'b1;
            cnt_reg  <= '0;
            last_reg <= long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
         end else if (abort || done) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/lccf_core.sv
// Conversion control, ranging and status flags of the light sensor.
`timescale 1ns/1ps
`default_nettype none
//
// Overview of operation
// - Conversions last 100 ms with time select 0, 800 ms with 1.
// - Conversion time select resets to 1, the long time.
// - Short time at ranges 5 and below loses one to three result bits.
// - Result format and bit weight do not depend on conversion time.
// - Mode 00 shutdown, 01 single shot, 10 or 11 continuous.
// - Mode field resets to shutdown.
// - Single shot reads 01 while converting, then returns to 00 itself.
// - Entering shutdown leaves ready, high and low flags untouched.
// - Overload flag is re-evaluated at every measurement.
// - Manual range reports any overload seen during the conversion.
// - Automatic ranging reports overload only at the highest range.
// - Automatic ranging aborts, steps range up and restarts on overload below the top range.
// - Ready flag sets at conversion end, clears on config read or non-shutdown write.
// - High flag sets after enough consecutive results above high threshold.
// - Low flag sets after enough consecutive results below low threshold.
// - Status flags are read-only and reset to zero.
// - Fault repeat code selects one, two, four or eight faults.
// - Config write aborts a running conversion and starts one if asked.
// - Range code 1100b is automatic, lower codes fixed, higher reserved.
module lccf_core
   import lccf_pkg::*;
#(
   parameter int unsigned CONV_SHORT_CYC = CONV_SHORT_MS * CLK_KHZ,
   parameter int unsigned CONV_LONG_CYC  = CONV_LONG_MS * CLK_KHZ
) (
   // Clock and control.
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        ce,
   // Decoded register access from the serial interface.
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   output logic             reg_rvalid,
   // Converter front end.
   output logic             adc_start,
   output logic [3:0]       adc_range,
   output logic             conv_active,
   input  wire logic        adc_overload,
   input  wire logic [11:0] adc_mantissa
);
   lccf_state_type state_reg;
   logic [3:0]     range_reg;
   logic           ct_reg;
   logic [1:0]     mode_reg;
   logic           ovf_reg;
   logic           crf_reg;
   logic           fh_reg;
   logic           fl_reg;
   logic           latch_reg;
   logic           pol_reg;
   logic           me_reg;
   logic [1:0]     fc_reg;
   logic [15:0]    low_reg;
   logic [15:0]    high_reg;
   logic [15:0]    result_reg;
   logic [3:0]     cur_range_reg;
   logic           ct_used_reg;
   logic           ovl_seen_reg;
   logic [15:0]    rdata_reg;
   logic           rvalid_reg;

   logic           cfg_wr;
   logic           cfg_rd;
   logic [1:0]     mode_w;
   logic           auto_range;
   logic           continuous;
   logic           step_up;
   logic           tmr_done;
   logic           done_ok;
   logic           tmr_start;
   logic           start_ct;
   logic [3:0]     start_range;
   logic [15:0]    result_next;
   logic           ovl_any;
   logic           hi_trip;
   logic           lo_trip;

   assign cfg_wr      = reg_wr && (reg_addr == ADDR_CONFIG);
   assign cfg_rd      = reg_rd && (reg_addr == ADDR_CONFIG);
   assign mode_w      = reg_wdata[MODE_MSB:MODE_LSB];
   assign auto_range  = (range_reg == RANGE_AUTO);
   assign continuous  = mode_reg[1];
   assign ovl_any     = ovl_seen_reg || adc_overload;

   // An overload in automatic ranging below the top range restarts at once, it never completes.
   assign step_up     = (state_reg == ST_CONV) && auto_range && adc_overload
                        && (cur_range_reg != RANGE_MAX) && !cfg_wr;
   assign done_ok     = tmr_done && (state_reg == ST_CONV) && !cfg_wr && !step_up;

   // A config write wins over a period end in the same cycle, since it aborts that conversion.
   assign tmr_start   = (cfg_wr && (mode_w != MODE_SHUTDOWN))
                        || step_up
                        || (done_ok && continuous);
   assign start_ct    = cfg_wr ? reg_wdata[CT_BIT] : ct_reg;
   assign start_range = cfg_wr ? ((reg_wdata[RANGE_MSB:RANGE_LSB] == RANGE_AUTO) ?
                                  RANGE_MIN : reg_wdata[RANGE_MSB:RANGE_LSB])
                               : (auto_range ? RANGE_MIN : range_reg);
   assign result_next = {cur_range_reg, adc_mantissa & res_mask(!ct_used_reg, cur_range_reg)};

   assign adc_start   = tmr_start;
   assign adc_range   = cur_range_reg;
   assign conv_active = (state_reg == ST_CONV);
   assign reg_rdata   = rdata_reg;
   assign reg_rvalid  = rvalid_reg;

   lccf_conv_timer #(
      .SHORT_CYC (CONV_SHORT_CYC),
      .LONG_CYC  (CONV_LONG_CYC),
      .CNT_W     (CONV_CNT_W)
   ) u_timer (
      .clock    (clock),
      .rst_b    (rst_b),
      .ce       (ce),
      .start    (tmr_start),
      .abort    (cfg_wr),
      .long_sel (start_ct),
      .done     (tmr_done)
   );

   lccf_fault_count u_high (
      .clock      (clock),
      .rst_b      (rst_b),
      .ce         (ce),
      .strobe     (done_ok),
      .fault      (lux_value(result_next) > lux_value(high_reg)),
      .repeat_sel (fc_reg),
      .trip       (hi_trip)
   );

   lccf_fault_count u_low (
      .clock      (clock),
      .rst_b      (rst_b),
      .ce         (ce),
      .strobe     (done_ok),
      .fault      (lux_value(result_next) < lux_value(low_reg)),
      .repeat_sel (fc_reg),
      .trip       (lo_trip)
   );

   // Conversion state.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
      end else if (ce) begin
         case (state_reg)
            ST_IDLE: begin
               if (tmr_start)
                  state_reg <= ST_CONV;
            end
            ST_CONV: begin
               if (cfg_wr && (mode_w == MODE_SHUTDOWN))
                  state_reg <= ST_IDLE;
               else if (done_ok && !continuous)
                  state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Writable configuration fields.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         range_reg <= CONFIG_RESET[RANGE_MSB:RANGE_LSB];
         ct_reg    <= CONFIG_RESET[CT_BIT];
         mode_reg  <= CONFIG_RESET[MODE_MSB:MODE_LSB];
         latch_reg <= CONFIG_RESET[LATCH_BIT];
         pol_reg   <= CONFIG_RESET[POL_BIT];
         me_reg    <= CONFIG_RESET[ME_BIT];
         fc_reg    <= CONFIG_RESET[FC_MSB:FC_LSB];
      end else if (ce) begin
         if (cfg_wr) begin
            range_reg <= reg_wdata[RANGE_MSB:RANGE_LSB];
            ct_reg    <= reg_wdata[CT_BIT];
            mode_reg  <= mode_w;
            latch_reg <= reg_wdata[LATCH_BIT];
            pol_reg   <= reg_wdata[POL_BIT];
            me_reg    <= reg_wdata[ME_BIT];
            fc_reg    <= reg_wdata[FC_MSB:FC_LSB];
         end else if (done_ok && (mode_reg == MODE_SINGLE)) begin
            mode_reg <= MODE_SHUTDOWN;
         end
      end
   end

   // Threshold registers.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         low_reg  <= LOW_RESET;
         high_reg <= HIGH_RESET;
      end else if (ce && reg_wr) begin
         if (reg_addr == ADDR_LOW)
            low_reg <= reg_wdata;
         if (reg_addr == ADDR_HIGH)
            high_reg <= reg_wdata;
      end
   end

   // Range of the running conversion and the overload seen within it.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cur_range_reg <= RANGE_MIN;
         ct_used_reg   <= CONFIG_RESET[CT_BIT];
         ovl_seen_reg  <= 1'b0;
      end else if (ce) begin
         if (step_up) begin
            cur_range_reg <= cur_range_reg + 4'h1;
            ovl_seen_reg  <= 1'b0;
         end else if (tmr_start) begin
            cur_range_reg <= start_range;
            ct_used_reg   <= start_ct;
            ovl_seen_reg  <= 1'b0;
         end else if (conv_active && adc_overload) begin
            ovl_seen_reg <= 1'b1;
         end
      end
   end

   // Result and overload flag, both refreshed only at a completed conversion.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         result_reg <= RESULT_RESET;
         ovf_reg    <= 1'b0;
      end else if (ce && done_ok) begin
         result_reg <= result_next;
         // In automatic ranging a completion with overload can only happen at the top range.
         ovf_reg    <= ovl_any;
      end
   end

   // Ready flag; a new completion wins over a clear in the same cycle.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         crf_reg <= 1'b0;
      end else if (ce) begin
         if (done_ok)
            crf_reg <= 1'b1;
         else if (cfg_rd || (cfg_wr && (mode_w != MODE_SHUTDOWN)))
            crf_reg <= 1'b0;
      end
   end

   // Threshold flags stay set until the host reads the configuration.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         fh_reg <= 1'b0;
         fl_reg <= 1'b0;
      end else if (ce) begin
         if (hi_trip)
            fh_reg <= 1'b1;
         else if (cfg_rd)
            fh_reg <= 1'b0;
         if (lo_trip)
            fl_reg <= 1'b1;
         else if (cfg_rd)
            fl_reg <= 1'b0;
      end
   end

   // Register read port, one cycle of latency.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdata_reg  <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         rvalid_reg <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_RESULT: rdata_reg <= result_reg;
               ADDR_CONFIG: rdata_reg <= {range_reg, ct_reg, mode_reg, ovf_reg, crf_reg, fh_reg, fl_reg,
                                          latch_reg, pol_reg, me_reg, fc_reg};
               ADDR_LOW:    rdata_reg <= low_reg;
               ADDR_HIGH:   rdata_reg <= high_reg;
               default:     rdata_reg <= 16'h0000;
            endcase
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_single_end;
      ce && done_ok && (mode_reg == MODE_SINGLE);
   endsequence

   sequence s_shutdown_write;
      ce && cfg_wr && (mode_w == MODE_SHUTDOWN) && !cfg_rd;
   endsequence

   chk_reset_values: assert property ($rose(rst_b) |-> ct_reg && (mode_reg == MODE_SHUTDOWN)
                                      && !ovf_reg && !crf_reg && !fh_reg && !fl_reg)
      else $error("configuration not at reset values after reset");

   chk_single_autoclear: assert property (s_single_end |=> (mode_reg == MODE_SHUTDOWN) ##0 !conv_active)
      else $error("single shot did not return to shutdown");

   chk_single_holds: assert property (ce && conv_active && (mode_reg == MODE_SINGLE) && !cfg_wr
                                      && !done_ok |=> (mode_reg == MODE_SINGLE))
      else $error("single shot mode changed during conversion");

   chk_ready_set: assert property (ce && done_ok |=> crf_reg)
      else $error("ready flag not set at conversion end");

   chk_ready_read_clear: assert property (ce && cfg_rd && !done_ok |=> !crf_reg)
      else $error("ready flag not cleared by configuration read");

   chk_shutdown_keeps: assert property (s_shutdown_write |=> $stable(crf_reg)
                                        && $stable(fh_reg) && $stable(fl_reg))
      else $error("shutdown write disturbed status flags");

   chk_write_idle: assert property (s_shutdown_write |=> !conv_active
                                    ##1 (!conv_active || $past(tmr_start)))
      else $error("conversion kept running after shutdown write");

   chk_auto_step: assert property (ce && step_up |=> (cur_range_reg == $past(cur_range_reg) + 4'h1)
                                   && conv_active)
      else $error("automatic ranging did not step up");

   chk_manual_range: assert property (conv_active && !auto_range |-> (cur_range_reg == range_reg))
      else $error("manual range not applied to conversion");

   chk_auto_ovf: assert property (ce && done_ok && auto_range && (cur_range_reg != RANGE_MAX)
                                  |=> !ovf_reg)
      else $error("overload reported below top range in automatic ranging");

   chk_high_flag: assert property (ce && hi_trip |=> fh_reg)
      else $error("high flag not set after fault run");

   chk_low_flag: assert property (ce && lo_trip |=> fl_reg)
      else $error("low flag not set after fault run");

   chk_continuous_next: assert property (ce && done_ok && continuous |-> adc_start ##1 conv_active)
      else $error("continuous mode did not restart");
endmodule
`default_nettype wire

// file: hdl/lccf_fault_count.sv
// Consecutive threshold fault counter.
`timescale 1ns/1ps
`default_nettype none
module lccf_fault_count
   import lccf_pkg::*;
(
   // Clock and control.
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       ce,
   // Measurement input.
   input  wire logic       strobe,
   input  wire logic       fault,
   input  wire logic [1:0] repeat_sel,
   // Fault run reached.
   output logic            trip
);
   logic [3:0] cnt_reg;

   // A run counts only while every measurement faults; one good result restarts it.
   assign trip = strobe && fault && ((cnt_reg + 4'h1) >= fault_need(repeat_sel));

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnt_reg <= 4'h0;
      end else if (ce && strobe) begin
         if (!fault)
            cnt_reg <= 4'h0;
         else if (cnt_reg < FAULT_MAX)
            cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: hdl/lccf_pkg.sv
// Shared constants, types and helper functions of the light conversion control block.
package lccf_pkg;
   // Register addresses.
   localparam logic [7:0]  ADDR_RESULT  = 8'h00;
   localparam logic [7:0]  ADDR_CONFIG  = 8'h01;
   localparam logic [7:0]  ADDR_LOW     = 8'h02;
   localparam logic [7:0]  ADDR_HIGH    = 8'h03;
   // Reset values.
   localparam logic [15:0] CONFIG_RESET = 16'hc810;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] LOW_RESET    = 16'h0000;
   localparam logic [15:0] HIGH_RESET   = 16'hffff;
   // Configuration field positions.
   localparam int RANGE_MSB = 15;
   localparam int RANGE_LSB = 12;
   localparam int CT_BIT    = 11;
   localparam int MODE_MSB  = 10;
   localparam int MODE_LSB  = 9;
   localparam int OVF_BIT   = 8;
   localparam int CRF_BIT   = 7;
   localparam int FH_BIT    = 6;
   localparam int FL_BIT    = 5;
   localparam int LATCH_BIT = 4;
   localparam int POL_BIT   = 3;
   localparam int ME_BIT    = 2;
   localparam int FC_MSB    = 1;
   localparam int FC_LSB    = 0;
   // Mode and range codes.
   localparam logic [1:0]  MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0]  MODE_SINGLE   = 2'h1;
   localparam logic [3:0]  RANGE_AUTO    = 4'hc;
   localparam logic [3:0]  RANGE_MAX     = 4'hb;
   localparam logic [3:0]  RANGE_MIN     = 4'h0;
   localparam logic [3:0]  RANGE_DROP1   = 4'h5;
   localparam logic [3:0]  RANGE_DROP2   = 4'h1;
   localparam logic [11:0] MASK_FULL     = 12'hfff;
   localparam logic [11:0] MASK_DROP1    = 12'hffe;
   localparam logic [11:0] MASK_DROP2    = 12'hffc;
   localparam logic [11:0] MASK_DROP3    = 12'hff8;
   localparam logic [3:0]  FAULT_MAX     = 4'h8;
   // Conversion timing.
   localparam int unsigned CONV_SHORT_MS = 100;
   localparam int unsigned CONV_LONG_MS  = 800;
   localparam int unsigned CLK_KHZ       = 125000;
   localparam int          CONV_CNT_W    = 27;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } lccf_state_type;

   // Expands an exponent and mantissa word into a linear value for comparison.
   // Wide enough for reserved exponents too, so an all-ones high limit is never exceeded.
   function automatic logic [26:0] lux_value(input logic [15:0] v);
      lux_value = {15'h0000, v[11:0]} << v[15:12];
   endfunction

   // Consecutive faults needed for each fault repeat code.
   function automatic logic [3:0] fault_need(input logic [1:0] sel);
      case (sel)
         2'h0:    fault_need = 4'h1;
         2'h1:    fault_need = 4'h2;
         2'h2:    fault_need = 4'h4;
         default: fault_need = 4'h8;
      endcase
   endfunction

   // Mantissa bits that stay meaningful for a given time and range.
   function automatic logic [11:0] res_mask(input logic short_time, input logic [3:0] range);
      if (!short_time || range > RANGE_DROP1)
         res_mask = MASK_FULL;
      else if (range == RANGE_DROP1)
         res_mask = MASK_DROP1;
      else if (range >= RANGE_DROP2)
         res_mask = MASK_DROP2;
      else
         res_mask = MASK_DROP3;
   endfunction
endpackage

// file: testbench/lccf_front_model.sv
// Behavioural light front end that answers the conversion controller.
`timescale 1ns/1ps
`default_nettype none
module lccf_front_model (
   // Controller side.
   input  wire logic        conv_active,
   input  wire logic [3:0]  adc_range,
   // Scene set by the bench.
   input  wire logic [22:0] light,
   input  wire logic        spike,
   // Converter outputs.
   output logic             adc_overload,
   output logic [11:0]      adc_mantissa
);
   logic [22:0] full;
   logic [22:0] shifted;
   always_comb begin
      full = {11'h000, 12'hfff} << adc_range;
      shifted = light >> adc_range;
      // A spike overloads only while integrating, so it cannot leak into a shutdown period.
      adc_overload = conv_active && (spike || light > full);
      adc_mantissa = (shifted > 23'h000fff) ? 12'hfff : shifted[11:0];
   end
endmodule
`default_nettype wire

// file: testbench/lccf_tb_top.sv
// Self-checking bench of the conversion control and flag logic.
`timescale 1ns/1ps
`default_nettype none
module lccf_tb_top;
   import lccf_pkg::*;
   localparam int NS = 20;
   localparam int NL = 50;
   logic        clock, rst_b, ce, reg_wr, reg_rd, reg_rvalid, adc_start, conv_active, adc_overload, spike;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [3:0]  adc_range;
   logic [11:0] adc_mantissa;
   logic [22:0] light;
   int          n_fail = 0;
   int          comparisons = 0;

   lccf_core #(.CONV_SHORT_CYC(NS), .CONV_LONG_CYC(NL)) u_lccf_core (
      .clock(clock), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_start(adc_start),
      .adc_range(adc_range), .conv_active(conv_active), .adc_overload(adc_overload), .adc_mantissa(adc_mantissa));
   lccf_front_model u_lccf_front_model (
      .conv_active(conv_active), .adc_range(adc_range), .light(light), .spike(spike),
      .adc_overload(adc_overload), .adc_mantissa(adc_mantissa));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic act(input logic v);
      check("conv active", {15'h0000, conv_active}, {15'h0000, v});
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      #1;
      if (a == ADDR_CONFIG)
         check("start pulse", {15'h0000, adc_start}, {15'h0000, d[MODE_MSB:MODE_LSB] != MODE_SHUTDOWN});
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] mask, input logic [15:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      check("read valid", {15'h0000, reg_rvalid}, 16'h0001);
      check(what, reg_rdata & mask, exp & mask);
      cyc(1);
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 4000 && conv_active !== 1'b0; i++)
         cyc(1);
      act(1'b0);
   endtask

   function automatic logic [15:0] cfg(input logic [3:0] r, input logic ct, input logic [1:0] m, input logic [1:0] fc);
      cfg = {r, ct, m, 4'h0, 3'h4, fc};
   endfunction

   // Mantissa bits that stay meaningful at short conversion time.
   function automatic logic [11:0] keep(input logic ct, input logic [3:0] r);
      if (ct || r > 4'h5)
         keep = 12'hfff;
      else if (r == 4'h5)
         keep = 12'hffe;
      else if (r != 4'h0)
         keep = 12'hffc;
      else
         keep = 12'hff8;
   endfunction

   task automatic s_reset;
      rchk("config reset", ADDR_CONFIG, 16'hffff, 16'hc810);
      rchk("low reset", ADDR_LOW, 16'hffff, 16'h0000);
      rchk("high reset", ADDR_HIGH, 16'hffff, 16'hffff);
      rchk("result reset", ADDR_RESULT, 16'hffff, 16'h0000);
      rchk("unmapped", 8'h07, 16'hffff, 16'h0000);
      wr(ADDR_RESULT, 16'h1234);
      wr(ADDR_CONFIG, 16'hc9f0);
      rchk("flags read only", ADDR_CONFIG, 16'hffff, 16'hc810);
      rchk("result read only", ADDR_RESULT, 16'hffff, 16'h0000);
   endtask

   task automatic s_single(input logic [3:0] r, input logic ct);
      int n;
      n = ct ? NL : NS;
      light = {11'h000, 12'habf} << r;
      wr(ADDR_CONFIG, cfg(r, ct, 2'h1, 2'h0));
      rchk("busy mode", ADDR_CONFIG, 16'h0680, 16'h0200);
      cyc(n - 4);
      act(1'b1);
      cyc(1);
      act(1'b0);
      rchk("done config", ADDR_CONFIG, 16'hff80, cfg(r, ct, 2'h0, 2'h0) | 16'h0080);
      rchk("result", ADDR_RESULT, 16'hffff, {r, 12'habf & keep(ct, r)});
      rchk("ready cleared", ADDR_CONFIG, 16'h0080, 16'h0000);
   endtask

   task automatic s_abort;
      wr(ADDR_CONFIG, cfg(4'h1, 1'b1, 2'h1, 2'h0));
      cyc(10);
      wr(ADDR_CONFIG, cfg(4'h1, 1'b0, 2'h1, 2'h0));
      cyc(NS - 2);
      act(1'b1);
      cyc(1);
      act(1'b0);
      wr(ADDR_CONFIG, cfg(4'h1, 1'b0, 2'h0, 2'h0));
      rchk("kept ready", ADDR_CONFIG, 16'h0680, 16'h0080);
   endtask

   task automatic s_auto(input logic [22:0] l);
      logic [3:0]  r;
      logic [22:0] m;
      r = 4'h0;
      while (r < 4'hb && l > ({11'h000, 12'hfff} << r))
         r++;
      m = l >> r;
      light = l;
      wr(ADDR_CONFIG, cfg(4'hc, 1'b1, 2'h1, 2'h0));
      wait_idle;
      check("auto range", {12'h000, adc_range}, {12'h000, r});
      rchk("auto result", ADDR_RESULT, 16'hffff, {r, (m > 23'h000fff) ? 12'hfff : m[11:0]});
      rchk("auto overload", ADDR_CONFIG, 16'h0100, {7'h00, l > 23'h7ff800, 8'h00});
   endtask

   task automatic s_spike;
      light = 23'h000100;
      wr(ADDR_CONFIG, cfg(4'h2, 1'b0, 2'h1, 2'h0));
      spike = 1'b1;
      cyc(3);
      spike = 1'b0;
      wait_idle;
      rchk("spike overload", ADDR_CONFIG, 16'h0100, 16'h0100);
      wr(ADDR_CONFIG, cfg(4'h2, 1'b0, 2'h1, 2'h0));
      wait_idle;
      rchk("clean overload", ADDR_CONFIG, 16'h0100, 16'h0000);
   endtask

   task automatic s_limits;
      int n;
      wr(ADDR_HIGH, 16'h0fff);
      rchk("high write", ADDR_HIGH, 16'hffff, 16'h0fff);
      for (int i = 0; i < 4; i++) begin
         n = 1 << i;
         light = 23'h000400;
         wr(ADDR_CONFIG, cfg(4'h6, 1'b0, 2'h1, i[1:0]));
         wait_idle;
         light = 23'h010000;
         wr(ADDR_CONFIG, cfg(4'h6, 1'b0, {1'b1, i[0]}, i[1:0]));
         rchk("high early", ADDR_CONFIG, 16'h0040, 16'h0000);
         cyc((n - 1) * NS);
         rchk("high early", ADDR_CONFIG, 16'h0040, 16'h0000);
         cyc(NS);
         rchk("high set", ADDR_CONFIG, 16'h0040, 16'h0040);
      end
      wr(ADDR_CONFIG, cfg(4'h6, 1'b0, 2'h0, 2'h0));
      wr(ADDR_LOW, 16'hb100);
      light = 23'h000400;
      wr(ADDR_CONFIG, cfg(4'h6, 1'b0, 2'h1, 2'h0));
      wait_idle;
      rchk("low set", ADDR_CONFIG, 16'h0060, 16'h0020);
   endtask

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
      light = 23'h000000;
      spike = 1'b0;
      cyc(16);
      rst_b = 1'b1;
      s_reset;
      for (int k = 0; k < 5; k++)
         s_single(k[3:0] * 4'h3 % 4'h7, k == 3);
      s_abort;
      s_auto(23'h012345);
      s_auto(23'h000123);
      s_auto(23'h7fffff);
      s_spike;
      s_limits;
      complete_run;
   end

   // The whole run needs about a thousand cycles, so this limit only trips on a hang.
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      complete_run;
   end
endmodule
`default_nettype wire
